// file: rtl/prad_top.v
// Notes on behaviour
// [RULE1] Result bits appear on the data pin only while chip select is high, and the host holds it high all frame.
// [RULE2] In conversion readout the data pin becomes an output and 36 bits leave, one per rising shift clock.
// [RULE3] Channel 1 goes first in bits 1-6 and channel 6 last in bits 31-36, each field least significant bit first.
// [RULE4] The chip select fall ending a conversion readout returns the block to display data input.
// [RULE5] Six channels of 6-bit conversion results are gathered for the serial readout.
// [RULE6] Rows are driven for a scan only after a key press or release is seen, and otherwise stay idle.
// [RULE7] Scanning stops at the chip select fall after two empty chip select pulses and one display data transfer.
// [RULE8] In lamp pwm dimming the measured lamp duty maps through 47 steps onto 8.98% down to 0.63% display duty.
// [RULE9] Lamp duty is measured from the digital high and low times of the dimming input.
// [RULE10] In analog dimming the display pulse count out of 2048 runs from 208 at the top to 13 at the lowest step.
// [RULE11] The analog step comes from comparing the dimming voltage against per-step thresholds.
// [RULE12] With day_dark_select high the duty follows the dimming input, with it low daylight duty is used.
// [RULE13] Daylight duty is 2032 pulse units out of 2048, one unit being four oscillator periods.
// [RULE14] An internal detector on the dimming input picks analog or lamp pwm dimming.
// [RULE15] The chip select fall ending a keyscan readout moves the block into conversion readout.
// [RULE16] The host releases the data line and gives at least 36 rising clocks in one frame to read all results.
// [RULE17] The dimming step is held until a new measurement or comparison completes, so the duty never glitches.
`timescale 1ns/1ns
`include "prad_consts.vh"
module prad_top (
  input  wire        core_clk_i,       // core clock
  input  wire        sys_rst_i,        // synchronous reset, high
  input  wire        cs_i,             // chip select pin
  input  wire        sclk_i,           // host shift clock pin
  input  wire        sdata_i,          // data pin level in
  output reg         sdata_o,          // data pin level out
  output reg         sdata_oe_o,       // data pin driven
  input  wire [35:0] adc_result_i,     // ch6..ch1 results
  input  wire        adc_valid_i,      // result word offered
  output reg         adc_ready_o,      // buffer can take word
  input  wire [3:0]  key_column_i,     // key columns, low = pressed
  output reg  [2:0]  key_row_o,        // key row drive
  input  wire        day_dark_select_i,// high = dark mode
  input  wire        dimming_input_i,  // dimming threshold level
  input  wire        dim_is_analog_i,  // detector: analog dimming
  input  wire [5:0]  analog_step_i,    // comparator bank step 1..49
  output reg  [1:0]  mode_o,           // current readout mode
  output reg         disp_pwm_o        // display pwm enable
);

  // analog step to pulse count out of 2048
  function [7:0] step_count;
    input [5:0] s;
    begin
      case (s)
        6'h01: step_count = 8'h0d;  6'h02: step_count = 8'h0f;  6'h03: step_count = 8'h0f;
        6'h04: step_count = 8'h10;  6'h05: step_count = 8'h11;  6'h06: step_count = 8'h12;
        6'h07: step_count = 8'h13;  6'h08: step_count = 8'h14;  6'h09: step_count = 8'h15;
        6'h0a: step_count = 8'h16;  6'h0b: step_count = 8'h17;  6'h0c: step_count = 8'h18;
        6'h0d: step_count = 8'h1a;  6'h0e: step_count = 8'h1c;  6'h0f: step_count = 8'h1e;
        6'h10: step_count = 8'h20;  6'h11: step_count = 8'h22;  6'h12: step_count = 8'h24;
        6'h13: step_count = 8'h26;  6'h14: step_count = 8'h28;  6'h15: step_count = 8'h2a;
        6'h16: step_count = 8'h2c;  6'h17: step_count = 8'h2e;  6'h18: step_count = 8'h30;
        6'h19: step_count = 8'h34;  6'h1a: step_count = 8'h38;  6'h1b: step_count = 8'h3c;
        6'h1c: step_count = 8'h40;  6'h1d: step_count = 8'h44;  6'h1e: step_count = 8'h46;
        6'h1f: step_count = 8'h4c;  6'h20: step_count = 8'h50;  6'h21: step_count = 8'h54;
        6'h22: step_count = 8'h58;  6'h23: step_count = 8'h5c;  6'h24: step_count = 8'h60;
        6'h25: step_count = 8'h68;  6'h26: step_count = 8'h70;  6'h27: step_count = 8'h78;
        6'h28: step_count = 8'h80;  6'h29: step_count = 8'h88;  6'h2a: step_count = 8'h90;
        6'h2b: step_count = 8'h98;  6'h2c: step_count = 8'ha0;  6'h2d: step_count = 8'ha8;
        6'h2e: step_count = 8'hb0;  6'h2f: step_count = 8'hb8;  6'h30: step_count = 8'hc0;
        6'h31: step_count = 8'hd0;
        default: step_count = 8'h0d;
      endcase
    end
  endfunction

  // lamp duty threshold in 1/256 for lamp step 1..46
  function [7:0] lamp_thr;
    input [5:0] s;
    begin
      case (s)
        6'h01: lamp_thr = 8'hfd;  6'h02: lamp_thr = 8'hf5;  6'h03: lamp_thr = 8'hef;  6'h04: lamp_thr = 8'heb;
        6'h05: lamp_thr = 8'he7;  6'h06: lamp_thr = 8'he2;  6'h07: lamp_thr = 8'hde;  6'h08: lamp_thr = 8'hd9;
        6'h09: lamp_thr = 8'hd4;  6'h0a: lamp_thr = 8'hd0;  6'h0b: lamp_thr = 8'hc9;  6'h0c: lamp_thr = 8'hc2;
        6'h0d: lamp_thr = 8'hbf;  6'h0e: lamp_thr = 8'hbb;  6'h0f: lamp_thr = 8'hb7;  6'h10: lamp_thr = 8'hb5;
        6'h11: lamp_thr = 8'hb2;  6'h12: lamp_thr = 8'haf;  6'h13: lamp_thr = 8'hab;  6'h14: lamp_thr = 8'ha8;
        6'h15: lamp_thr = 8'ha5;  6'h16: lamp_thr = 8'ha2;  6'h17: lamp_thr = 8'h9d;  6'h18: lamp_thr = 8'h98;
        6'h19: lamp_thr = 8'h96;  6'h1a: lamp_thr = 8'h93;  6'h1b: lamp_thr = 8'h91;  6'h1c: lamp_thr = 8'h8f;
        6'h1d: lamp_thr = 8'h8c;  6'h1e: lamp_thr = 8'h89;  6'h1f: lamp_thr = 8'h86;  6'h20: lamp_thr = 8'h83;
        6'h21: lamp_thr = 8'h81;  6'h22: lamp_thr = 8'h7e;  6'h23: lamp_thr = 8'h7c;  6'h24: lamp_thr = 8'h7a;
        6'h25: lamp_thr = 8'h78;  6'h26: lamp_thr = 8'h76;  6'h27: lamp_thr = 8'h75;  6'h28: lamp_thr = 8'h73;
        6'h29: lamp_thr = 8'h70;  6'h2a: lamp_thr = 8'h6d;  6'h2b: lamp_thr = 8'h6b;  6'h2c: lamp_thr = 8'h6a;
        6'h2d: lamp_thr = 8'h68;  6'h2e: lamp_thr = 8'h66;
        default: lamp_thr = 8'h64;
      endcase
    end
  endfunction

  // three-stage sync of all pin inputs: cs, sclk, data, dim, day, analog flag, cols
  wire [9:0] pins_raw = {key_column_i, dim_is_analog_i, day_dark_select_i, dimming_input_i, sdata_i, sclk_i, cs_i};
  reg  [9:0] sync1;
  reg  [9:0] sync2;
  reg  [9:0] sync3;
  reg  [9:0] pin;
  wire [9:0] next_pin = (sync2 & sync3) | (pin & (sync2 | sync3));
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      sync1 <= 10'h3c0;
      sync2 <= 10'h3c0;
      sync3 <= 10'h3c0;
      pin   <= 10'h3c0;
    end else begin
      sync1 <= pins_raw;
      sync2 <= sync1;
      sync3 <= sync2;
      pin   <= next_pin;         // changes once stages two and three agree
    end
  end
  wire       cs_rise   = next_pin[0] & ~pin[0];
  wire       cs_fall   = ~next_pin[0] & pin[0];
  wire       sclk_rise = next_pin[1] & ~pin[1] & pin[0];
  wire       dim_rise  = next_pin[3] & ~pin[3];
  wire [3:0] cols      = pin[9:6];

  // two-entry result buffer
  reg  [35:0] buf_mem [0:1];
  reg         wr_ptr;
  reg         rd_ptr;
  reg  [1:0]  buf_cnt;
  wire        buf_push = adc_valid_i & adc_ready_o;
  wire        buf_pop  = cs_rise & (mode_o == `PRAD_MODE_ADC) & (buf_cnt != 2'h0);
  wire [1:0]  next_buf_cnt = buf_cnt + {1'b0, buf_push} - {1'b0, buf_pop};
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      wr_ptr      <= 1'b0;
      rd_ptr      <= 1'b0;
      buf_cnt     <= 2'h0;
      adc_ready_o <= 1'b0;
    end else begin
      if (buf_push) begin
        buf_mem[wr_ptr] <= adc_result_i;  // [RULE5]
        wr_ptr          <= ~wr_ptr;
      end
      if (buf_pop)
        rd_ptr <= ~rd_ptr;
      buf_cnt     <= next_buf_cnt;
      adc_ready_o <= (next_buf_cnt != 2'h2);
    end
  end

  // keyscan: idle rows low, scan one row low at a time
  reg  [3:0]  cols_seen;
  reg         scanning;
  reg  [1:0]  scan_row;
  reg  [11:0] row_timer;
  reg  [11:0] key_bits;
  reg  [1:0]  cs_pulses;
  reg  [5:0]  frame_clks;
  reg  [35:0] out_sr;
  reg  [5:0]  out_cnt;
  wire        stop_scan = cs_fall & (frame_clks != 6'h0) & (mode_o == `PRAD_MODE_DISP) & (cs_pulses == 2'h2);
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      cols_seen <= 4'hf;
      scanning  <= 1'b0;
      scan_row  <= 2'h0;
      row_timer <= 12'h0;
      key_bits  <= 12'h0;
      key_row_o <= 3'h0;
    end else if (!scanning) begin
      key_row_o <= 3'h0;
      cols_seen <= cols;
      if (cols != cols_seen) begin
        scanning  <= 1'b1;             // [RULE6]
        scan_row  <= 2'h0;
        row_timer <= 12'h0;
        key_row_o <= 3'h6;
      end
    end else if (stop_scan) begin
      scanning  <= 1'b0;               // [RULE7]
      key_row_o <= 3'h0;
      cols_seen <= cols;
    end else if (row_timer == `PRAD_ROW_CYC - 1) begin
      row_timer <= 12'h0;
      case (scan_row)
        2'h0:    key_bits[3:0]  <= ~cols;
        2'h1:    key_bits[7:4]  <= ~cols;
        default: key_bits[11:8] <= ~cols;
      endcase
      scan_row  <= (scan_row == 2'h2) ? 2'h0 : scan_row + 2'h1;
      key_row_o <= (scan_row == 2'h0) ? 3'h5 : (scan_row == 2'h1) ? 3'h3 : 3'h6;
    end else begin
      row_timer <= row_timer + 12'h1;
    end
  end

  // serial link: mode changes, frame load and bit shifting
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      mode_o     <= `PRAD_MODE_DISP;
      cs_pulses  <= 2'h0;
      frame_clks <= 6'h0;
      out_sr     <= 36'h0;
      out_cnt    <= 6'h0;
      sdata_o    <= 1'b0;
      sdata_oe_o <= 1'b0;
    end else if (cs_rise) begin
      frame_clks <= 6'h0;
      out_cnt    <= 6'h0;
      sdata_o    <= 1'b0;
      sdata_oe_o <= (mode_o != `PRAD_MODE_DISP);   // [RULE1] [RULE2]
      if (mode_o == `PRAD_MODE_KEY)
        out_sr <= {24'h0, key_bits};
      else if (buf_cnt != 2'h0)
        out_sr <= buf_mem[rd_ptr];                  // [RULE3] ch1 in low bits
    end else if (cs_fall) begin
      sdata_oe_o <= 1'b0;                           // [RULE1]
      sdata_o    <= 1'b0;
      if (frame_clks == 6'h0) begin
        cs_pulses <= (cs_pulses == 2'h2) ? 2'h2 : cs_pulses + 2'h1;
        if (cs_pulses == 2'h1)
          mode_o <= `PRAD_MODE_DISP;                // two empty pulses
      end else begin
        cs_pulses <= 2'h0;
        if (mode_o == `PRAD_MODE_KEY)
          mode_o <= `PRAD_MODE_ADC;                 // [RULE15]
        else if (mode_o == `PRAD_MODE_ADC)
          mode_o <= `PRAD_MODE_DISP;                // [RULE4]
        else if (scanning & ~stop_scan)
          mode_o <= `PRAD_MODE_KEY;                 // key data waits for host
      end
    end else if (sclk_rise) begin
      if (frame_clks != 6'h3f)
        frame_clks <= frame_clks + 6'h1;
      if (sdata_oe_o & (out_cnt != `PRAD_ADC_BITS)) begin
        sdata_o <= out_sr[0];                       // [RULE2] [RULE3] lsb first
        out_sr  <= {1'b0, out_sr[35:1]};
        out_cnt <= out_cnt + 6'h1;                  // [RULE16] host gives 36 edges
      end else begin
        sdata_o <= 1'b0;
      end
    end
  end

  // lamp pwm measurement from digital high and low times
  reg  [19:0] per_cnt;
  reg  [19:0] high_cnt;
  reg  [5:0]  lamp_step;
  reg  [5:0]  i;
  reg  [5:0]  next_lamp_step;
  reg  [27:0] high_scaled;
  always @* begin
    high_scaled    = {high_cnt, 8'h0};
    next_lamp_step = 6'h2f;
    for (i = 6'h2e; i != 6'h0; i = i - 6'h1)
      if (high_scaled >= per_cnt * lamp_thr(i))     // [RULE8]
        next_lamp_step = i;
  end
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      per_cnt   <= 20'h0;
      high_cnt  <= 20'h0;
      lamp_step <= 6'h2f;
    end else if (dim_rise) begin
      lamp_step <= next_lamp_step;                  // [RULE9] [RULE17]
      per_cnt   <= 20'h1;
      high_cnt  <= 20'h1;
    end else begin
      if (per_cnt != 20'hfffff)
        per_cnt <= per_cnt + 20'h1;
      if (pin[3] & (high_cnt != 20'hfffff))
        high_cnt <= high_cnt + 20'h1;               // [RULE9]
    end
  end

  // display pwm frame: 2048 units of four clocks each
  reg  [2:0]  unit_div;
  reg  [10:0] unit_cnt;
  reg  [10:0] duty;
  reg  [10:0] next_duty;
  reg  [5:0]  ana_step;
  always @* begin
    ana_step = analog_step_i;
    if (ana_step == 6'h0)
      ana_step = 6'h1;
    if (ana_step > `PRAD_ANA_STEPS)
      ana_step = `PRAD_ANA_STEPS;                   // [RULE11] comparator step clamp
    if (!pin[4])
      next_duty = `PRAD_DAY_COUNT;                  // [RULE12] [RULE13]
    else if (pin[5])
      next_duty = {3'h0, step_count(ana_step)};     // [RULE10] [RULE14]
    else
      next_duty = {3'h0, step_count(6'h30 - lamp_step)}; // [RULE8] [RULE14]
  end
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      unit_div   <= 3'h0;
      unit_cnt   <= 11'h0;
      duty       <= 11'h0;
      disp_pwm_o <= 1'b0;
    end else begin
      unit_div <= (unit_div == `PRAD_UNIT_CYC - 3'h1) ? 3'h0 : unit_div + 3'h1;
      if (unit_div == `PRAD_UNIT_CYC - 3'h1) begin
        unit_cnt <= unit_cnt + 11'h1;
        if (unit_cnt == 11'h7ff)
          duty <= next_duty;                        // [RULE17] change only at frame end
      end
      disp_pwm_o <= (unit_cnt < duty);
    end
  end

endmodule // prad_top

// file: rtl/prad_consts.vh
`ifndef PRAD_CONSTS_VH
`define PRAD_CONSTS_VH
// core clock rate
`define PRAD_CLK_MHZ       25
// link framing
`define PRAD_ADC_BITS      36
`define PRAD_KEY_BITS      12
`define PRAD_CH_BITS       6
`define PRAD_CNT_W         6
// readout modes
`define PRAD_MODE_DISP     2'h0
`define PRAD_MODE_KEY      2'h1
`define PRAD_MODE_ADC      2'h2
// dimming frame: one pulse unit is four oscillator periods
`define PRAD_UNIT_CYC      3'h4
`define PRAD_FRAME_UNITS   12'h800
`define PRAD_DAY_COUNT     11'h7f0
`define PRAD_PWM_STEPS     47
`define PRAD_ANA_STEPS     6'h31
// keyscan row slot time and derived cycle count
`define PRAD_ROW_NS        128000
`define PRAD_ROW_CYC       ((`PRAD_ROW_NS * `PRAD_CLK_MHZ) / 1000)
// lamp period counter width
`define PRAD_MEAS_W        20
`endif

// file: dv/prad_sva.sv
`timescale 1ns/1ns
module prad_sva (
  input wire       core_clk_i,  // core clock
  input wire       sys_rst_i,   // sync reset
  input wire       cs_i,        // chip select pin
  input wire       sclk_i,      // shift clock pin
  input wire       sdata_o,     // data drive value
  input wire       sdata_oe_o,  // data drive enable
  input wire       adc_valid_i, // word offered
  input wire       adc_ready_o, // buffer has room
  input wire [2:0] key_row_o,   // row drive
  input wire [1:0] mode_o       // readout mode
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  // data pin ownership follows mode and chip select
  a_idle_no_drive: assert property (mode_o == 2'h0 |-> !sdata_oe_o) else $error("drive in display mode");
  a_oe_needs_cs: assert property (sdata_oe_o |-> $past(cs_i, 4) || $past(cs_i, 6)) else $error("drive without cs");
  a_cs_low_release: assert property (!cs_i [*8] |-> !sdata_oe_o) else $error("drive after cs low");
  // shifted bit holds while the shift clock rests
  a_sdata_steady: assert property ((cs_i && !sclk_i) [*8] |-> $stable(sdata_o)) else $error("data moved w/o clock");
  // mode sequence and its timing against chip select
  a_mode_into_adc: assert property (mode_o == 2'h2 && $past(mode_o) != 2'h2 |-> $past(mode_o) == 2'h1)
    else $error("bad entry to conversion mode");
  a_mode_out_adc: assert property ($past(mode_o) == 2'h2 && mode_o != 2'h2 |-> mode_o == 2'h0)
    else $error("bad exit from conversion mode");
  a_mode_cs_low: assert property ($changed(mode_o) |-> !cs_i && !$past(cs_i, 2)) else $error("mode moved in frame");
  // all rows low when idle, otherwise one row pulled low at a time
  a_row_pattern: assert property (key_row_o inside {3'h0, 3'h6, 3'h5, 3'h3}) else $error("bad row drive");
  // two words in a row with no pop fill the buffer
  a_buf_full: assert property ((!cs_i && !$past(cs_i) && !$past(cs_i, 2) && !$past(cs_i, 3) && adc_valid_i
    && adc_ready_o) [*2] |-> ##2 !adc_ready_o) else $error("buffer overfilled");
endmodule // prad_sva

bind prad_top prad_sva i_sva (.core_clk_i, .sys_rst_i, .cs_i, .sclk_i, .sdata_o, .sdata_oe_o, .adc_valid_i,
  .adc_ready_o, .key_row_o, .mode_o);

// file: dv/prad_host.sv
`timescale 1ns/1ns
module prad_host (
  input  wire core_clk_i, // pacing clock
  input  wire line_i,     // data pin level
  output reg  cs_o,       // chip select
  output reg  sclk_o,     // shift clock
  output reg  d_o,        // display data out
  output reg  d_oe_o      // host drives data
);
  // idle: deselected, clock parked low
  initial begin
    cs_o = 1'b0;
    sclk_o = 1'b0;
    d_o = 1'b0;
    d_oe_o = 1'b0;
  end
  // frame of n clocks at 320 ns; bit k read just before the next rise
  task automatic frame(input int n, input bit wr, output logic [35:0] cap);
    cap = 36'h0;
    @(negedge core_clk_i);
    cs_o = 1'b1;
    d_oe_o = wr;
    repeat (8) @(negedge core_clk_i);
    for (int k = 0; k < n; k++) begin
      sclk_o = 1'b1;
      repeat (4) @(negedge core_clk_i);
      sclk_o = 1'b0;
      d_o = ~d_o;
      repeat (4) @(negedge core_clk_i);
      if (k < 36) cap[k] = line_i;
    end
    cs_o = 1'b0;
    d_oe_o = 1'b0;
    repeat (16) @(negedge core_clk_i);
  endtask
endmodule // prad_host

// file: dv/tb.sv
`timescale 1ns/1ns
`include "prad_consts.vh"
module tb;
  reg         core_clk_i = 1'b0;
  reg         sys_rst_i = 1'b1;
  reg  [35:0] adc_result_i, w0, w1, cap;
  reg         adc_valid_i, day_dark_select_i, last_lvl = 1'b0;
  reg         dimming_input_i = 1'b0, dim_is_analog_i = 1'b1;
  int         lamp_ph = 0, lamp_hi = 0;
  reg  [3:0]  key_column_i;
  reg  [5:0]  analog_step_i;
  reg  [31:0] seed = 32'h3fb02880;
  wire        cs, sclk, hd, hoe, sdata_o, sdata_oe_o, adc_ready_o, disp_pwm_o;
  wire [2:0]  key_row_o;
  wire [1:0]  mode_o;
  int         err_count = 0, checked = 0, cycles = 0;
  // pin level: device, else host, else a toggling floating value
  wire line = sdata_oe_o ? sdata_o : (hoe ? hd : ~last_lvl);
  // 25 MHz core clock
  always #20 core_clk_i = ~core_clk_i;
  // lamp pwm source: 2560-clock period, lamp_hi clocks high
  always @(negedge core_clk_i) begin
    lamp_ph         <= (lamp_ph == 2559) ? 0 : lamp_ph + 1;
    dimming_input_i <= (lamp_ph < lamp_hi);
  end
  // float model and hang guard
  always @(posedge core_clk_i) begin
    last_lvl <= line;
    cycles++;
    if (cycles == 90000) begin
      err_count++;
      end_sim();
    end
  end
  prad_top i_prad_top (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .cs_i(cs), .sclk_i(sclk), .sdata_i(line),
    .sdata_o(sdata_o), .sdata_oe_o(sdata_oe_o), .adc_result_i(adc_result_i), .adc_valid_i(adc_valid_i),
    .adc_ready_o(adc_ready_o), .key_column_i(key_column_i), .key_row_o(key_row_o),
    .day_dark_select_i(day_dark_select_i), .dimming_input_i(dimming_input_i), .dim_is_analog_i(dim_is_analog_i),
    .analog_step_i(analog_step_i), .mode_o(mode_o), .disp_pwm_o(disp_pwm_o));
  prad_host i_host (.core_clk_i(core_clk_i), .line_i(line), .cs_o(cs), .sclk_o(sclk), .d_o(hd), .d_oe_o(hoe));
  // xorshift generator
  function automatic [31:0] xs(input [31:0] s);
    reg [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    xs = t ^ (t << 5);
  endfunction
  // serial image of a result word: channel fields in order, lsb first
  function automatic [35:0] exp_conv(input [35:0] w);
    for (int k = 0; k < 36; k++) exp_conv[k] = w[6 * (k / 6) + (k % 6)];
  endfunction
  // high clocks per 2048-unit frame
  function automatic int exp_hi(input dark, input [5:0] st);
    exp_hi = 4 * (!dark ? 2032 : (st >= 6'd49) ? 208 : 13);
  endfunction
  task automatic chk(input string name, input logic [35:0] seen, input logic [35:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task automatic nextw(output [35:0] w);
    seed = xs(seed);
    w[31:0] = seed;
    seed = xs(seed);
    w[35:32] = seed[3:0];
  endtask
  // set dimming inputs, let a frame wrap, count one full frame
  task automatic duty(input dark, input [5:0] st);
    int hi;
    hi = 0;
    day_dark_select_i = dark;
    analog_step_i = st;
    repeat (8192) @(negedge core_clk_i);
    repeat (8192) begin
      @(negedge core_clk_i);
      if (disp_pwm_o === 1'b1) hi++;
    end
    chk("pwm high clocks", hi, exp_hi(dark, st));
  endtask
  // dark lamp pwm dimming: let two measurements and a wrap pass, count one frame
  task automatic lamp(input int hi_clk, input int units);
    int hi;
    hi = 0;
    day_dark_select_i = 1'b1;
    dim_is_analog_i = 1'b0;
    lamp_hi = hi_clk;
    repeat (16384) @(negedge core_clk_i);
    repeat (8192) begin
      @(negedge core_clk_i);
      if (disp_pwm_o === 1'b1) hi++;
    end
    chk("lamp pwm high clocks", hi, 4 * units);
    dim_is_analog_i = 1'b1;
  endtask
  // display frame, key frame, then conversion frame, check the word
  task automatic readout(input [35:0] w);
    i_host.frame(8, 1'b1, cap);
    chk("mode after display", mode_o, 2'h1);
    i_host.frame(12, 1'b0, cap);
    chk("mode after key", mode_o, 2'h2);
    i_host.frame(36, 1'b0, cap);
    chk("conv word", cap, exp_conv(w));
    chk("mode after conv", mode_o, 2'h0);
  endtask
  task automatic end_sim();
    if (err_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // main sequence
  initial begin
    adc_result_i = 36'h0;
    adc_valid_i = 1'b0;
    key_column_i = 4'hf;
    day_dark_select_i = 1'b0;
    analog_step_i = 6'h31;
    repeat (4) @(negedge core_clk_i);
    sys_rst_i = 1'b0;
    chk("reset mode", mode_o, 2'h0);
    chk("reset rows", key_row_o, 3'h0);
    nextw(w0);
    nextw(w1);
    @(negedge core_clk_i);
    adc_valid_i = 1'b1;
    adc_result_i = w0;
    @(negedge core_clk_i);
    adc_result_i = w1;
    @(negedge core_clk_i);
    adc_valid_i = 1'b0;
    @(negedge core_clk_i);
    chk("ready when full", adc_ready_o, 1'b0);
    key_column_i = 4'he;
    for (int i = 0; i < 8000 && key_row_o === 3'h0; i++) @(negedge core_clk_i);
    chk("scan started", key_row_o != 3'h0, 1'b1);
    readout(w0);
    readout(w1);
    chk("ready after pops", adc_ready_o, 1'b1);
    i_host.frame(0, 1'b0, cap);
    i_host.frame(0, 1'b0, cap);
    i_host.frame(8, 1'b1, cap);
    chk("rows after stop", key_row_o, 3'h0);
    chk("mode after stop", mode_o, 2'h0);
    duty(1'b0, 6'h31);
    seed = xs(seed);
    duty(1'b1, 6'h31 + {3'h0, seed[2:0]});
    duty(1'b1, 6'h00);
    lamp(2500, 176); // 97.66% lamp duty is step 2, 8.59% display
    end_sim();
  end
endmodule // tb
